/* rtl/ttlc_float.sv */
`timescale 1ns/1ns
`default_nettype none
module ttlc_float (
    // float causes
    input wire logic float_pin_i,
    input wire logic float_bit_i,
    input wire logic mclk_lost_i,
    input wire logic tx_clk_lost_i,
    input wire logic remote_loop_i,
    input wire logic mclk_pattern_i,
    input wire logic tx_off_i,
    input wire logic reset_hold_i,
    // result
    output logic next_float_o
);
    logic clk_loss_float;
    // tx clock is irrelevant when loopback or master clock times the data
    assign clk_loss_float = tx_clk_lost_i & ~remote_loop_i & ~mclk_pattern_i;
    // any cause floats the pair
    assign next_float_o = float_pin_i | float_bit_i
        | mclk_lost_i
        | clk_loss_float
        | tx_off_i
        | reset_hold_i;
endmodule
`default_nettype wire

/* rtl/ttlc_map.svh */
// What this block does
// - tx termination: top bit internal/external, low bits impedance
// - template codes per cable: E1, T1 grades, J1
// - float pin or channel float bit floats pair
// - floated pair keeps internal transmit logic running
// - master clock loss floats every transmit pair
// - tx clock loss floats, except loopback or pattern
// - any reset leaves transmit pair floated
// - power-down bit stops path and floats pair
// - rx termination: top bit disables, low bits impedance
// - T1/J1 gain resets 110110, two percent steps
// - T1 templates: 16 samples per UI, UI3/UI4 zero
// - J1 template equals shortest T1 grade template
// - longest grade peaks 0111111, three negative tail samples
// - template codes 11xx select arbitrary waveform mode
`ifndef TTLC_MAP_SVH
`define TTLC_MAP_SVH
// register offsets
`define TTLC_OFS_TX_CFG0 8'h02
`define TTLC_OFS_TX_CFG1 8'h03
`define TTLC_OFS_GAIN 8'h04
`define TTLC_OFS_TERM 8'h1a
// field positions
`define TTLC_CFG0_TX_OFF 4
`define TTLC_CFG1_FLOAT 5
`define TTLC_TERM_TX_EXT 5
`define TTLC_TERM_RX_EXT 2
// reset values
`define TTLC_RST_BYTE 8'h00
`define TTLC_GAIN_T1 6'h36
`define TTLC_GAIN_E1 6'h21
// template codes
`define TTLC_TPL_E1_75 4'h0
`define TTLC_TPL_E1_120 4'h1
`define TTLC_TPL_T1_FIRST 4'h2
`define TTLC_TPL_T1_LAST 4'h6
`define TTLC_TPL_J1 4'h7
`define TTLC_TPL_ARB_TOP 2'h3
// sample index width and wrap point
`define TTLC_IDX_LAST 6'h3f
`endif

/* rtl/ttlc_pkg.sv */
`default_nettype none
package ttlc_pkg;
    // family decoded from a template code
    typedef enum logic [2:0] {
        TTLC_FAM_E1,
        TTLC_FAM_T1,
        TTLC_FAM_J1,
        TTLC_FAM_ARB,
        TTLC_FAM_RSVD
    } ttlc_fam_e;
    // one sign-magnitude sample
    typedef logic [6:0] ttlc_sample_t;
    // template select field
    typedef logic [3:0] ttlc_code_t;
endpackage
`default_nettype wire

/* rtl/ttlc_rom.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ttlc_map.svh"
module ttlc_rom (
    // lookup
    input wire logic [3:0] code_i,
    input wire logic [1:0] ui_i,
    input wire logic [3:0] samp_i,
    // sample
    output ttlc_pkg::ttlc_sample_t sample_o
);
    // first UI of the five cable grades, shortest first
    localparam ttlc_pkg::ttlc_sample_t UI1 [5][16] = '{
        '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24,
          7'h23, 7'h4a, 7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43},
        '{7'h1b, 7'h2e, 7'h2c, 7'h2a, 7'h29, 7'h28, 7'h27, 7'h26,
          7'h25, 7'h50, 7'h4f, 7'h4d, 7'h4a, 7'h48, 7'h46, 7'h44},
        '{7'h1f, 7'h34, 7'h2f, 7'h2c, 7'h2b, 7'h2a, 7'h29, 7'h28,
          7'h25, 7'h57, 7'h53, 7'h50, 7'h4b, 7'h48, 7'h46, 7'h44},
        '{7'h20, 7'h3b, 7'h35, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h2a,
          7'h28, 7'h58, 7'h58, 7'h53, 7'h4c, 7'h48, 7'h46, 7'h44},
        '{7'h20, 7'h3f, 7'h38, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c,
          7'h29, 7'h5f, 7'h5e, 7'h57, 7'h4f, 7'h49, 7'h47, 7'h44}};
    // second UI tail: only the first three positions carry samples
    localparam ttlc_pkg::ttlc_sample_t UI2 [5][3] = '{
        '{7'h42, 7'h41, 7'h00},
        '{7'h43, 7'h42, 7'h41},
        '{7'h43, 7'h42, 7'h41},
        '{7'h43, 7'h42, 7'h41},
        '{7'h43, 7'h42, 7'h41}};
    logic [2:0] grade;
    logic hit;
    // J1 reuses the shortest grade table
    always_comb
    begin
        hit = 1'b1;
        grade = 3'h0;
        if (code_i == `TTLC_TPL_J1)
            grade = 3'h0;
        else if (code_i >= `TTLC_TPL_T1_FIRST && code_i <= `TTLC_TPL_T1_LAST)
            grade = 3'(code_i - `TTLC_TPL_T1_FIRST);
        else
            hit = 1'b0;
    end
    // E1 and arbitrary shapes are not held here, they read as zero
    always_comb
    begin
        sample_o = 7'h00;
        if (hit && ui_i == 2'h0)
            sample_o = UI1[grade][samp_i];
        else if (hit && ui_i == 2'h1 && samp_i < 4'h3)
            sample_o = UI2[grade][samp_i[1:0]];
    end
endmodule
`default_nettype wire

/* rtl/ttlc_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ttlc_map.svh"
module ttlc_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // line status and pins
    input wire logic tx_line_float_i,
    input wire logic mclk_lost_i,
    input wire logic tx_line_clock_lost_i,
    input wire logic remote_loop_i,
    input wire logic mclk_pattern_i,
    // transmit line pair control
    output logic tx_line_pair_oe_o,
    output logic tx_path_on_o,
    output ttlc_pkg::ttlc_sample_t tx_sample_o,
    output logic arb_mode_o,
    output logic [5:0] amplitude_gain_step_o,
    // terminations
    output logic tx_term_ext_o,
    output logic [1:0] tx_term_sel_o,
    output logic rx_term_off_o,
    output logic [1:0] rx_term_sel_o
);
    logic [7:0] tx_config_zero;
    logic [7:0] tx_config_one;
    logic [7:0] line_termination_select;
    logic [5:0] amplitude_gain_step;
    logic reset_hold;
    logic [5:0] sample_idx;
    logic next_float;
    ttlc_pkg::ttlc_sample_t rom_sample;
    ttlc_pkg::ttlc_fam_e cur_fam;
    ttlc_pkg::ttlc_fam_e new_fam;

    // template code to family, used for both stored and incoming codes
    function automatic ttlc_pkg::ttlc_fam_e fam_of(input logic [3:0] code);
        if (code[3:2] == `TTLC_TPL_ARB_TOP)
            return ttlc_pkg::TTLC_FAM_ARB;
        if (code == `TTLC_TPL_E1_75 || code == `TTLC_TPL_E1_120)
            return ttlc_pkg::TTLC_FAM_E1;
        if (code >= `TTLC_TPL_T1_FIRST && code <= `TTLC_TPL_T1_LAST)
            return ttlc_pkg::TTLC_FAM_T1;
        if (code == `TTLC_TPL_J1)
            return ttlc_pkg::TTLC_FAM_J1;
        return ttlc_pkg::TTLC_FAM_RSVD;
    endfunction

    function automatic logic is_t1j1(input ttlc_pkg::ttlc_fam_e fam);
        return fam == ttlc_pkg::TTLC_FAM_T1 || fam == ttlc_pkg::TTLC_FAM_J1;
    endfunction

    assign cur_fam = fam_of(tx_config_one[3:0]);
    assign new_fam = fam_of(reg_wdata_i[3:0]);

    // config zero: holds the power-down bit
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            tx_config_zero <= `TTLC_RST_BYTE;
        else if (reg_wr_i && reg_addr_i == `TTLC_OFS_TX_CFG0)
            tx_config_zero <= reg_wdata_i;
    end

    // config one: template select and channel float bit
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            tx_config_one <= `TTLC_RST_BYTE;
        else if (reg_wr_i && reg_addr_i == `TTLC_OFS_TX_CFG1)
            tx_config_one <= reg_wdata_i;
    end

    // termination select, tx field high, rx field low
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            line_termination_select <= `TTLC_RST_BYTE;
        else if (reg_wr_i && reg_addr_i == `TTLC_OFS_TERM)
            line_termination_select <= reg_wdata_i;
    end

    // gain: reset default, reloaded when the template family changes to T1/J1 or E1
    // so a T1/J1 shape never runs with the E1 default scale
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            amplitude_gain_step <= `TTLC_GAIN_T1;
        else if (reg_wr_i && reg_addr_i == `TTLC_OFS_GAIN)
            amplitude_gain_step <= reg_wdata_i[5:0];
        else if (reg_wr_i && reg_addr_i == `TTLC_OFS_TX_CFG1 && new_fam != cur_fam)
        begin
            if (is_t1j1(new_fam))
                amplitude_gain_step <= `TTLC_GAIN_T1;
            else if (new_fam == ttlc_pkg::TTLC_FAM_E1)
                amplitude_gain_step <= `TTLC_GAIN_E1;
        end
    end

    // reset keeps the pair floated until software touches config zero
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            reset_hold <= 1'b1;
        else if (reg_wr_i && reg_addr_i == `TTLC_OFS_TX_CFG0)
            reset_hold <= 1'b0;
    end

    // read port, one cycle latency, unmapped reads give zero
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            reg_rdata_o <= `TTLC_RST_BYTE;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `TTLC_OFS_TX_CFG0: reg_rdata_o <= tx_config_zero;
                `TTLC_OFS_TX_CFG1: reg_rdata_o <= tx_config_one;
                `TTLC_OFS_GAIN: reg_rdata_o <= {2'h0, amplitude_gain_step};
                `TTLC_OFS_TERM: reg_rdata_o <= line_termination_select;
                default: reg_rdata_o <= `TTLC_RST_BYTE;
            endcase
        end
    end

    // float causes gathered in one place
    ttlc_float u_float (
        .float_pin_i(tx_line_float_i),
        .float_bit_i(tx_config_one[`TTLC_CFG1_FLOAT]),
        .mclk_lost_i(mclk_lost_i),
        .tx_clk_lost_i(tx_line_clock_lost_i),
        .remote_loop_i(remote_loop_i),
        .mclk_pattern_i(mclk_pattern_i),
        .tx_off_i(tx_config_zero[`TTLC_CFG0_TX_OFF]),
        .reset_hold_i(reset_hold),
        .next_float_o(next_float)
    );

    // driver enable and path power
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_line_pair_oe_o <= 1'b0;
            tx_path_on_o <= 1'b0;
        end
        else
        begin
            tx_line_pair_oe_o <= ~next_float;
            tx_path_on_o <= ~tx_config_zero[`TTLC_CFG0_TX_OFF];
        end
    end

    // sample index walks 4 UIs of 16; float only gates the driver
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            sample_idx <= 6'h00;
        else if (tx_config_zero[`TTLC_CFG0_TX_OFF])
            sample_idx <= 6'h00;
        else
            sample_idx <= sample_idx + 6'h01;
    end

    ttlc_rom u_rom (
        .code_i(tx_config_one[3:0]),
        .ui_i(sample_idx[5:4]),
        .samp_i(sample_idx[3:0]),
        .sample_o(rom_sample)
    );

    // shaped sample, mode flag and gain out
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_sample_o <= 7'h00;
            arb_mode_o <= 1'b0;
            amplitude_gain_step_o <= `TTLC_GAIN_T1;
        end
        else
        begin
            tx_sample_o <= tx_config_zero[`TTLC_CFG0_TX_OFF] ? 7'h00 : rom_sample;
            arb_mode_o <= cur_fam == ttlc_pkg::TTLC_FAM_ARB;
            amplitude_gain_step_o <= amplitude_gain_step;
        end
    end

    // terminations; external tx matching in T1/J1 is left to software
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_term_ext_o <= 1'b0;
            tx_term_sel_o <= 2'h0;
            rx_term_off_o <= 1'b0;
            rx_term_sel_o <= 2'h0;
        end
        else
        begin
            tx_term_ext_o <= line_termination_select[`TTLC_TERM_TX_EXT];
            tx_term_sel_o <= line_termination_select[`TTLC_TERM_TX_EXT-1 -: 2];
            rx_term_off_o <= line_termination_select[`TTLC_TERM_RX_EXT];
            rx_term_sel_o <= line_termination_select[`TTLC_TERM_RX_EXT-1 -: 2];
        end
    end

    // checks
    property p_float_pin;
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_line_float_i |=> !tx_line_pair_oe_o;
    endproperty
    a_float_pin: assert property (p_float_pin) else $error("pin float ignored");

    property p_float_bit;
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_config_one[`TTLC_CFG1_FLOAT] |=> !tx_line_pair_oe_o;
    endproperty
    a_float_bit: assert property (p_float_bit) else $error("bit float ignored");

    property p_keeps_running;
        @(posedge sys_clk_i) disable iff (rst_i)
        (tx_line_float_i && !tx_config_zero[`TTLC_CFG0_TX_OFF])[*2]
            |-> sample_idx == $past(sample_idx) + 6'h01;
    endproperty
    a_keeps_running: assert property (p_keeps_running) else $error("tx logic stopped");

    property p_mclk_loss;
        @(posedge sys_clk_i) disable iff (rst_i)
        mclk_lost_i |=> !tx_line_pair_oe_o;
    endproperty
    a_mclk_loss: assert property (p_mclk_loss) else $error("mclk loss not floated");

    property p_txclk_loss;
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_line_clock_lost_i && !remote_loop_i && !mclk_pattern_i |=> !tx_line_pair_oe_o;
    endproperty
    a_txclk_loss: assert property (p_txclk_loss) else $error("tx clock loss not floated");

    property p_reset_hold;
        @(posedge sys_clk_i)
        $fell(rst_i) |-> !tx_line_pair_oe_o ##1 !tx_line_pair_oe_o;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("driven after reset");

    property p_power_down;
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_config_zero[`TTLC_CFG0_TX_OFF] |=> !tx_line_pair_oe_o && !tx_path_on_o;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down not honoured");

    property p_rx_term;
        @(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> rx_term_off_o == $past(line_termination_select[`TTLC_TERM_RX_EXT]);
    endproperty
    a_rx_term: assert property (p_rx_term) else $error("rx term wrong");

    property p_gain_reset;
        @(posedge sys_clk_i)
        $fell(rst_i) |-> amplitude_gain_step == `TTLC_GAIN_T1;
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong");

    property p_upper_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        sample_idx[5] |-> rom_sample == 7'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("UI3/UI4 not zero");

    property p_j1_first;
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_config_one[3:0] == `TTLC_TPL_J1 && sample_idx == 6'h00 |-> rom_sample == 7'h17;
    endproperty
    a_j1_first: assert property (p_j1_first) else $error("J1 start wrong");

    property p_long_peak;
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_config_one[3:0] == `TTLC_TPL_T1_LAST && sample_idx == 6'h01
            |-> rom_sample == 7'h3f;
    endproperty
    a_long_peak: assert property (p_long_peak) else $error("long grade peak wrong");

    property p_arb;
        @(posedge sys_clk_i) disable iff (rst_i)
        tx_config_one[3:2] == `TTLC_TPL_ARB_TOP |=> arb_mode_o;
    endproperty
    a_arb: assert property (p_arb) else $error("arbitrary mode missed");

    property p_oe_inverse;
        @(posedge sys_clk_i) disable iff (rst_i)
        !next_float |=> tx_line_pair_oe_o;
    endproperty
    a_oe_inverse: assert property (p_oe_inverse) else $error("oe not restored");
endmodule
`default_nettype wire

/* sim/ttlc_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ttlc_map.svh"
`define CHK(nm, e, g) \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
        bad_count++; \
        $display("[ERR] %s expected %h seen %h", nm, (e), (g)); \
    end
module ttlc_test;
    logic sys_clk_i;
    logic rst_i;
    logic [7:0] reg_addr_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic [4:0] causes;
    logic tx_line_pair_oe_o;
    logic tx_path_on_o;
    ttlc_pkg::ttlc_sample_t tx_sample_o;
    logic arb_mode_o;
    logic [5:0] amplitude_gain_step_o;
    logic tx_term_ext_o;
    logic [1:0] tx_term_sel_o;
    logic rx_term_off_o;
    logic [1:0] rx_term_sel_o;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // expected first two intervals: shortest grade (also J1) and longest grade
    logic [6:0] j1_a [16] = '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24,
        7'h23, 7'h4a, 7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43};
    logic [6:0] j1_b [3] = '{7'h42, 7'h41, 7'h00};
    logic [6:0] lg_a [16] = '{7'h20, 7'h3f, 7'h38, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c,
        7'h29, 7'h5f, 7'h5e, 7'h57, 7'h4f, 7'h49, 7'h47, 7'h44};
    logic [6:0] lg_b [3] = '{7'h43, 7'h42, 7'h41};
    // pin causes {float, mclk lost, tclk lost, loopback, pattern} and expected enable
    logic [5:0] ftab [9] = '{{5'h10, 1'b0}, {5'h08, 1'b0}, {5'h04, 1'b0}, {5'h06, 1'b1},
        {5'h05, 1'b1}, {5'h07, 1'b1}, {5'h02, 1'b1}, {5'h01, 1'b1}, {5'h00, 1'b1}};

    ttlc_top u_ttlc_top (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .tx_line_float_i(causes[4]),
        .mclk_lost_i(causes[3]),
        .tx_line_clock_lost_i(causes[2]),
        .remote_loop_i(causes[1]),
        .mclk_pattern_i(causes[0]),
        .tx_line_pair_oe_o(tx_line_pair_oe_o),
        .tx_path_on_o(tx_path_on_o),
        .tx_sample_o(tx_sample_o),
        .arb_mode_o(arb_mode_o),
        .amplitude_gain_step_o(amplitude_gain_step_o),
        .tx_term_ext_o(tx_term_ext_o),
        .tx_term_sel_o(tx_term_sel_o),
        .rx_term_off_o(rx_term_off_o),
        .rx_term_sel_o(rx_term_sel_o)
    );

    // free running 100 MHz clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic conclude();
        $display("counts: comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            conclude();
        end
    end

    // land just past an edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK("reg_rdata_o", e, reg_rdata_o)
    endtask

    // select a template, restart the index, then follow all 64 samples
    // apart from reset the index only parks under power down, so a pulse of that bit gives a known start
    task automatic stream(input logic [3:0] code, input logic flt,
        input logic [6:0] ua [16], input logic [6:0] ub [3]);
        logic [6:0] e;
        wr(`TTLC_OFS_TX_CFG1, {2'b00, flt, 1'b0, code});
        wr(`TTLC_OFS_TX_CFG0, 8'h10); // park index at zero
        wr(`TTLC_OFS_TX_CFG0, 8'h00); // release
        for (int i = 0; i < 64; i++)
        begin
            e = (i < 16) ? ua[i] : ((i < 19) ? ub[i - 16] : 7'h00);
            tick(1);
            `CHK("tx_sample_o", e, tx_sample_o) // sample per cycle
        end
    endtask

    initial
    begin
        logic [2:0] c;
        rst_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 8'h00;
        causes = 5'h00;
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        tick(1);
        // reset state and the hold that keeps the pair floated
        `CHK("oe", 1'b0, tx_line_pair_oe_o) // floated after reset
        `CHK("gain", 6'h36, amplitude_gain_step_o) // gain default
        rd_chk(`TTLC_OFS_GAIN, 8'h36); // gain default
        rd_chk(8'h55, 8'h00); // unmapped offset reads zero
        rd_chk(`TTLC_OFS_TERM, 8'h00); // internal matching after reset
        tick(8);
        `CHK("oe", 1'b0, tx_line_pair_oe_o) // still floated
        wr(`TTLC_OFS_TX_CFG0, 8'h00); // ends the reset hold
        tick(1);
        `CHK("oe", 1'b1, tx_line_pair_oe_o) // no cause left
        $display("reset test done");
        // each pin float cause, with the loopback and pattern exceptions
        for (int k = 0; k < 9; k++)
        begin
            @(posedge sys_clk_i);
            causes <= ftab[k][5:1];
            tick(1);
            `CHK("oe", ftab[k][0], tx_line_pair_oe_o)
        end
        $display("float test done");
        // code is still E1, so external transmit matching is legal here
        for (int k = 0; k < 8; k++)
        begin
            c = k[2:0];
            wr(`TTLC_OFS_TERM, {2'b00, c, ~c}); // E1 only for external
            tick(1);
            `CHK("tx_term_ext_o", c[2], tx_term_ext_o)
            `CHK("tx_term_sel_o", c[1:0], tx_term_sel_o)
            `CHK("rx_term_off_o", ~c[2], rx_term_off_o)
            `CHK("rx_term_sel_o", ~c[1:0], rx_term_sel_o)
            rd_chk(`TTLC_OFS_TERM, {2'b00, c, ~c}); // readback
        end
        wr(`TTLC_OFS_TERM, 8'h12); // internal tx matching before T1
        $display("termination test done");
        // templates: shortest grade, J1 while floated, longest grade
        stream(4'h2, 1'b0, j1_a, j1_b);
        `CHK("gain", 6'h36, amplitude_gain_step_o) // T1 family gain
        stream(4'h7, 1'b1, j1_a, j1_b); // same as shortest, while floated
        `CHK("oe", 1'b0, tx_line_pair_oe_o) // channel float bit
        stream(4'h6, 1'b0, lg_a, lg_b);
        wr(`TTLC_OFS_GAIN, 8'h37);
        tick(1);
        `CHK("gain", 6'h37, amplitude_gain_step_o) // one step up
        for (int k = 8; k < 16; k++)
        begin
            wr(`TTLC_OFS_TX_CFG1, k[7:0]);
            tick(1);
            `CHK("arb_mode_o", (k >= 12), arb_mode_o)
        end
        wr(`TTLC_OFS_GAIN, 8'h36); // unscaled arbitrary pulse
        rd_chk(`TTLC_OFS_GAIN, 8'h36);
        wr(`TTLC_OFS_TX_CFG1, 8'h01);
        tick(1);
        `CHK("gain", 6'h21, amplitude_gain_step_o) // E1 family reload
        $display("template test done");
        // power down while a J1 pulse would otherwise be sent
        wr(`TTLC_OFS_TX_CFG1, 8'h07);
        wr(`TTLC_OFS_TX_CFG0, 8'h10);
        tick(1);
        `CHK("oe", 1'b0, tx_line_pair_oe_o) // power down floats
        `CHK("path", 1'b0, tx_path_on_o) // path off
        for (int k = 0; k < 8; k++)
        begin
            tick(1);
            `CHK("tx_sample_o", 7'h00, tx_sample_o)
        end
        wr(`TTLC_OFS_TX_CFG0, 8'h00);
        tick(1);
        `CHK("oe", 1'b1, tx_line_pair_oe_o)
        `CHK("path", 1'b1, tx_path_on_o)
        $display("power down test done");
        // reset again in mid-run, released on an edge like every other input
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        tick(1);
        `CHK("oe", 1'b0, tx_line_pair_oe_o) // first edge after release
        tick(3);
        `CHK("oe", 1'b0, tx_line_pair_oe_o)
        `CHK("gain", 6'h36, amplitude_gain_step_o)
        rd_chk(`TTLC_OFS_TX_CFG1, 8'h00); // float bit cleared by reset
        wr(`TTLC_OFS_TX_CFG0, 8'h00);
        tick(1);
        `CHK("oe", 1'b1, tx_line_pair_oe_o)
        $display("second reset test done");
        conclude();
    end
endmodule
`default_nettype wire
